// *** rtl/ihps_defines.svh ***
`ifndef IHPS_DEFINES_SVH
`define IHPS_DEFINES_SVH

// register byte offsets on the avalon slave
`define IHPS_CTRL_OFS      6'h00
`define IHPS_CH1_IN_OFS    6'h04
`define IHPS_CH1_OUT_OFS   6'h08
`define IHPS_CH1_STAT_OFS  6'h0c
`define IHPS_CH2_IN_OFS    6'h10
`define IHPS_CH2_OUT_OFS   6'h14
`define IHPS_CH2_STAT_OFS  6'h18
`define IHPS_SIG_OFS       6'h1c
`define IHPS_PIN_OFS       6'h20

// control register field positions
`define IHPS_CTRL_HPE      0
`define IHPS_CTRL_SDE      1
`define IHPS_CTRL_C2E      2
`define IHPS_CTRL_FA20E    3
`define IHPS_CTRL_P43D     4
`define IHPS_CTRL_P44D     5
`define IHPS_CTRL_P45D     6
`define IHPS_CTRL_RESET    7'h00

// status byte field positions
`define IHPS_STAT_OBF      0
`define IHPS_STAT_IBF      1
`define IHPS_STAT_CMD      3
`define IHPS_STAT_USR_LO   4

// host signal register field positions
`define IHPS_SIG_A20       0
`define IHPS_SIG_IRQA      1
`define IHPS_SIG_IRQB      2
`define IHPS_SIG_IRQC      3
`define IHPS_SIG_RESET     4'h0

// level that a shut-down input function is held at
`define IHPS_FIXED_LEVEL   1'b0

`endif

// *** rtl/ihps_pkg.sv ***
package ihps_pkg;

  // software control bits
  typedef struct packed {
    logic p45_dir;
    logic p44_dir;
    logic p43_dir;
    logic fast_a20_enable;
    logic chan_two_enable;
    logic shutdown_enable;
    logic host_port_enable;
  } ihps_ctrl_t;

  // per channel state: two data bytes, status
  typedef struct packed {
    logic [7:0] in_data;
    logic [7:0] out_data;
    logic [3:0] user;
    logic       cmd;
    logic       in_full;
    logic       out_full;
  } ihps_chan_t;

endpackage : ihps_pkg

// *** rtl/ihps_top.sv ***
// Behaviour
// - port usable only when port enable set
// - slave mode gates every host pin function
// - two channels, only selected one answers
// - one shared byte bus, both directions
// - drive gate a20 and three irq lines
// - four data, two status, one control byte
// - shutdown floats data bus, fixes inputs
// - stay shut down while shutdown input low
// - shutdown input high restores normal operation
// - shutdown honoured only slave mode, enabled
// - second select from primary pin normally
// - second select from alternate pin with a20
// - gate a20 replaces primary second select
// - irq b needs chan two, p43 direction
// - irq a needs p44 direction
// - irq c needs p45 direction
// - conditional pins shut only when selected
// - shared input functions also held fixed
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`include "ihps_defines.svh"

module ihps_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // avalon-mm slave
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // chip mode
  input  wire logic        i_single_chip_mode,
  // host pins
  input  wire logic        i_chan_one_select_n,
  input  wire logic        i_chan_two_select_n,
  input  wire logic        i_alt_chan_two_select_n,
  input  wire logic        i_host_addr_bit,
  input  wire logic        i_host_read_strobe_n,
  input  wire logic        i_host_write_strobe_n,
  input  wire logic [7:0]  i_host_data_bus,
  output logic      [7:0]  o_host_data_bus,
  output logic             o_host_data_bus_oe,
  output logic             o_gate_a20_out,
  output logic             o_gate_a20_out_oe,
  output logic             o_host_irq_line_a,
  output logic             o_host_irq_line_a_oe,
  output logic             o_host_irq_line_b,
  output logic             o_host_irq_line_b_oe,
  output logic             o_host_irq_line_c,
  output logic             o_host_irq_line_c_oe,
  input  wire logic        i_port_shutdown_n,
  // shared input functions, passed to the rest of the chip
  input  wire logic        i_ext_irq_or_adc_trigger,
  input  wire logic        i_timer_clk_or_hsync_in,
  input  wire logic        i_timer_reset_or_csync_in,
  output logic             o_ext_irq_or_adc_trigger,
  output logic             o_timer_clk_or_hsync_in,
  output logic             o_timer_reset_or_csync_in
);

  ihps_pkg::ihps_ctrl_t ctrl;
  ihps_pkg::ihps_chan_t chan [2];
  logic [3:0]           sig;
  logic                 ack;
  logic                 slave_mode;
  logic                 shutdown;
  logic                 alt_sel;
  logic                 cs1_n;
  logic                 cs2_n;
  logic                 addr_bit;
  logic                 rd_n;
  logic                 wr_n;
  logic                 rd_prev_n;
  logic                 wr_prev_n;
  logic                 rd_chan;
  logic                 rd_addr;
  logic                 host_sel;
  logic                 host_chan;
  logic                 wr_event;
  logic                 rd_done;
  logic                 cpu_wr;
  logic                 cpu_rd;
  logic [7:0]           next_host_data;
  logic [31:0]          next_readdata;

  // mode and shutdown decode
  assign slave_mode = i_single_chip_mode & ctrl.host_port_enable;
  assign shutdown   = slave_mode & ctrl.shutdown_enable
                      & ~i_port_shutdown_n;
  assign alt_sel    = ctrl.chan_two_enable & ctrl.fast_a20_enable;

  // host inputs as seen inside; shut-down inputs read inactive
  always_comb begin
    cs1_n    = 1'b1;
    cs2_n    = 1'b1;
    addr_bit = `IHPS_FIXED_LEVEL;
    rd_n     = 1'b1;
    wr_n     = 1'b1;
    if (slave_mode && !shutdown) begin
      cs1_n    = i_chan_one_select_n;
      addr_bit = i_host_addr_bit;
      rd_n     = i_host_read_strobe_n;
      wr_n     = i_host_write_strobe_n;
      if (ctrl.chan_two_enable) begin
        cs2_n = alt_sel ? i_alt_chan_two_select_n
                        : i_chan_two_select_n;
      end
    end
  end

  // channel one wins if the host asserts both selects at once
  assign host_sel  = ~cs1_n | ~cs2_n;
  assign host_chan = cs1_n;

  // strobe history for edge detection
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rd_prev_n <= 1'b1;
      wr_prev_n <= 1'b1;
    end else begin
      rd_prev_n <= rd_n;
      wr_prev_n <= wr_n;
    end
  end

  // remember which register a read targets, for its closing edge
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rd_chan <= 1'b0;
      rd_addr <= 1'b0;
    end else if (!rd_n && host_sel) begin
      rd_chan <= host_chan;
      rd_addr <= addr_bit;
    end
  end

  // write taken on the falling strobe; read ends on the rising one
  assign wr_event = wr_prev_n & ~wr_n & host_sel;
  assign rd_done  = ~rd_prev_n & rd_n;

  // avalon handshake: every access answers in its second cycle
  assign cpu_rd            = i_avs_read & ack;
  assign cpu_wr            = i_avs_write & ack & i_avs_byteenable[0];
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_avs_read | i_avs_write) & ~ack;
    end
  end

  // software control register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctrl <= `IHPS_CTRL_RESET;
    end else if (cpu_wr && i_avs_address == `IHPS_CTRL_OFS) begin
      ctrl <= i_avs_writedata[6:0];
    end
  end

  // levels presented on gate a20 and the irq lines
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sig <= `IHPS_SIG_RESET;
    end else if (cpu_wr && i_avs_address == `IHPS_SIG_OFS) begin
      sig <= i_avs_writedata[3:0];
    end
  end

  // channel state; a setting event beats a clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      for (int c = 0; c < 2; c++) begin
        chan[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        // cpu side: reading the inbound byte frees the slot
        if (cpu_rd && i_avs_address == (c[0] ? `IHPS_CH2_IN_OFS
                                              : `IHPS_CH1_IN_OFS)) begin
          chan[c].in_full <= 1'b0;
        end
        if (cpu_wr && i_avs_address == (c[0] ? `IHPS_CH2_STAT_OFS
                                              : `IHPS_CH1_STAT_OFS)) begin
          chan[c].user <= i_avs_writedata[7:4];
        end
        // host read of the data byte empties the outbound slot
        if (rd_done && rd_chan == c[0] && !rd_addr) begin
          chan[c].out_full <= 1'b0;
        end
        if (cpu_wr && i_avs_address == (c[0] ? `IHPS_CH2_OUT_OFS
                                              : `IHPS_CH1_OUT_OFS)) begin
          chan[c].out_data <= i_avs_writedata[7:0];
          chan[c].out_full <= 1'b1;
        end
        // host write: address bit marks command versus data
        if (wr_event && host_chan == c[0]) begin
          chan[c].in_data <= i_host_data_bus;
          chan[c].cmd     <= addr_bit;
          chan[c].in_full <= 1'b1;
        end
      end
    end
  end

  // byte the host would see: data register or status
  always_comb begin
    next_host_data = 8'h00;
    if (addr_bit) begin
      next_host_data[`IHPS_STAT_OBF] = chan[host_chan].out_full;
      next_host_data[`IHPS_STAT_IBF] = chan[host_chan].in_full;
      next_host_data[`IHPS_STAT_CMD] = chan[host_chan].cmd;
      next_host_data[7:4]            = chan[host_chan].user;
    end else begin
      next_host_data = chan[host_chan].out_data;
    end
  end

  // registered so the bus does not glitch; one cycle behind the pins
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_host_data_bus <= 8'h00;
    end else begin
      o_host_data_bus <= next_host_data;
    end
  end

  // shutdown forces cs and strobes inactive, so the bus floats
  assign o_host_data_bus_oe = host_sel & ~rd_n;

  // outbound pins, each only where its function is selected
  assign o_gate_a20_out       = sig[`IHPS_SIG_A20];
  assign o_gate_a20_out_oe    = slave_mode & ctrl.fast_a20_enable;
  assign o_host_irq_line_a    = sig[`IHPS_SIG_IRQA];
  assign o_host_irq_line_a_oe = slave_mode & ctrl.p44_dir;
  assign o_host_irq_line_b    = sig[`IHPS_SIG_IRQB];
  assign o_host_irq_line_b_oe = slave_mode & ctrl.chan_two_enable
                                & ctrl.p43_dir;
  assign o_host_irq_line_c    = sig[`IHPS_SIG_IRQC];
  assign o_host_irq_line_c_oe = slave_mode & ctrl.p45_dir;

  // shared input functions held while their pin is shut down
  assign o_ext_irq_or_adc_trigger  = (shutdown && alt_sel)
                                     ? `IHPS_FIXED_LEVEL
                                     : i_ext_irq_or_adc_trigger;
  assign o_timer_clk_or_hsync_in   = (shutdown && o_host_irq_line_b_oe)
                                     ? `IHPS_FIXED_LEVEL
                                     : i_timer_clk_or_hsync_in;
  assign o_timer_reset_or_csync_in = (shutdown && o_host_irq_line_c_oe)
                                     ? `IHPS_FIXED_LEVEL
                                     : i_timer_reset_or_csync_in;

  // software read mux; unmapped offsets read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (i_avs_address)
      `IHPS_CTRL_OFS:     next_readdata[6:0] = ctrl;
      `IHPS_CH1_IN_OFS:   next_readdata[7:0] = chan[0].in_data;
      `IHPS_CH1_OUT_OFS:  next_readdata[7:0] = chan[0].out_data;
      `IHPS_CH1_STAT_OFS: next_readdata[7:0] = {chan[0].user, chan[0].cmd, 1'b0,
                                                chan[0].in_full, chan[0].out_full};
      `IHPS_CH2_IN_OFS:   next_readdata[7:0] = chan[1].in_data;
      `IHPS_CH2_OUT_OFS:  next_readdata[7:0] = chan[1].out_data;
      `IHPS_CH2_STAT_OFS: next_readdata[7:0] = {chan[1].user, chan[1].cmd, 1'b0,
                                                chan[1].in_full, chan[1].out_full};
      `IHPS_SIG_OFS:      next_readdata[3:0] = sig;
      `IHPS_PIN_OFS:      next_readdata[2:0] = {alt_sel, shutdown, slave_mode};
      default:            next_readdata = 32'h0000_0000;
    endcase
  end

  // sampled in the waiting cycle, stands at the answering edge
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack) begin
      o_avs_readdata <= next_readdata;
    end
  end

endmodule : ihps_top

// *** test/ihps_asserts.sv ***
module ihps_asserts (
  input wire logic        i_core_clk,
  input wire logic        i_reset,
  input wire logic [5:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_single_chip_mode,
  input wire logic        i_chan_one_select_n,
  input wire logic        i_host_read_strobe_n,
  input wire logic        i_port_shutdown_n,
  input wire logic        o_host_data_bus_oe,
  input wire logic        o_gate_a20_out_oe,
  input wire logic        o_host_irq_line_a_oe,
  input wire logic        o_host_irq_line_b_oe,
  input wire logic        o_host_irq_line_c_oe,
  input wire logic        i_timer_reset_or_csync_in,
  input wire logic        o_timer_reset_or_csync_in
);
  logic [6:0] ctl;
  logic       wr_ctl;
  logic       slave;
  logic       shut;
  // shadow of the control byte, taken only when the write really lands
  assign wr_ctl = i_avs_write && !o_avs_waitrequest && i_avs_address == 6'h00
                  && i_avs_byteenable[0];
  always_ff @(posedge i_core_clk) begin
    if (i_reset) ctl <= 7'h00;
    else if (wr_ctl) ctl <= i_avs_writedata[6:0];
  end
  // derived modes, same edge as the design's own register
  assign slave = i_single_chip_mode & ctl[0];
  assign shut = slave & ctl[1] & !i_port_shutdown_n;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_one_wait;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  property p_wait; $rose(i_avs_read || i_avs_write) |-> s_one_wait; endproperty
  a_wait: assert property (p_wait) else $error("avalon answer not after one wait");
  property p_oe_guard;
    o_host_data_bus_oe |-> !i_host_read_strobe_n && slave && !shut;
  endproperty
  a_oe_guard: assert property (p_oe_guard) else $error("bus driven out of turn");
  property p_oe_answer;
    slave && !shut && !i_chan_one_select_n && !i_host_read_strobe_n |-> o_host_data_bus_oe;
  endproperty
  a_oe_answer: assert property (p_oe_answer) else $error("selected read not driven");
  property p_a20; o_gate_a20_out_oe == (slave && ctl[3]); endproperty
  a_a20: assert property (p_a20) else $error("gate a20 enable wrong");
  property p_irqa; o_host_irq_line_a_oe == (slave && ctl[5]); endproperty
  a_irqa: assert property (p_irqa) else $error("irq a enable wrong");
  property p_irqb; o_host_irq_line_b_oe == (slave && ctl[2] && ctl[4]); endproperty
  a_irqb: assert property (p_irqb) else $error("irq b enable wrong");
  property p_irqc; o_host_irq_line_c_oe == (slave && ctl[6]); endproperty
  a_irqc: assert property (p_irqc) else $error("irq c enable wrong");
  property p_csync;
    o_timer_reset_or_csync_in == ((shut && ctl[6]) ? 1'b0 : i_timer_reset_or_csync_in);
  endproperty
  a_csync: assert property (p_csync) else $error("shared input not held");
endmodule : ihps_asserts

bind ihps_top ihps_asserts u_chk (.*);

// *** test/ihps_host_model.sv ***
module ihps_host_model (
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_bus,
  output logic      [2:0] o_sel_n,
  output logic            o_addr,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic      [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle host: nothing selected, strobes high
  initial begin
    {o_sel_n, o_addr, o_rd_n, o_wr_n, o_data} = {3'h7, 1'b0, 2'h3, 8'h00};
  end
  // one access; sel bit0 chan one, bit1 chan two, bit2 alt chan two
  task automatic xfer(input logic [2:0] s, input logic a, input logic w,
                      input logic [7:0] d, input int slow, output logic [7:0] q);
    @(posedge i_core_clk);
    o_sel_n <= s;
    o_addr <= a;
    o_data <= w ? d : ~o_data;
    o_wr_n <= !w;
    o_rd_n <= w;
    repeat (2 + slow) @(posedge i_core_clk);
    q = i_bus;
    // strobes stay high a cycle at least before the next access
    {o_sel_n, o_rd_n, o_wr_n} <= 5'h1f;
    o_data <= ~o_data; // no pull on the bus, so show the inverse
  endtask : xfer
endmodule : ihps_host_model

// *** test/isa_host_port_shutdown_tb.sv ***
module isa_host_port_shutdown_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, rd, wr, scm, sd_n, oe, wreq, ha, hrd_n, hwr_n;
  logic [5:0]  adr;
  logic [31:0] wd, rdat, q;
  logic [2:0]  sh, hsel_n;
  logic [7:0]  dout, hdat, bus, h, d;
  int          err_total, comparisons;
  // device owns the shared bus only while its driver is enabled
  assign bus = oe ? dout : hdat;
  ihps_top dut (
    .i_core_clk(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_byteenable(4'h1), .i_avs_writedata(wd),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_single_chip_mode(scm),
    .i_chan_one_select_n(hsel_n[0]), .i_chan_two_select_n(hsel_n[1]),
    .i_alt_chan_two_select_n(hsel_n[2]), .i_host_addr_bit(ha),
    .i_host_read_strobe_n(hrd_n), .i_host_write_strobe_n(hwr_n), .i_host_data_bus(bus),
    .o_host_data_bus(dout), .o_host_data_bus_oe(oe), .o_gate_a20_out(),
    .o_gate_a20_out_oe(), .o_host_irq_line_a(), .o_host_irq_line_a_oe(),
    .o_host_irq_line_b(), .o_host_irq_line_b_oe(), .o_host_irq_line_c(),
    .o_host_irq_line_c_oe(), .i_port_shutdown_n(sd_n), .i_ext_irq_or_adc_trigger(sh[0]),
    .i_timer_clk_or_hsync_in(sh[1]), .i_timer_reset_or_csync_in(sh[2]),
    .o_ext_irq_or_adc_trigger(), .o_timer_clk_or_hsync_in(), .o_timer_reset_or_csync_in()
  );
  ihps_host_model host (
    .i_core_clk(clk), .i_bus(bus), .o_sel_n(hsel_n), .o_addr(ha), .o_rd_n(hrd_n),
    .o_wr_n(hwr_n), .o_data(hdat)
  );
  // core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // avalon master; holds the request until waitrequest is seen low
  task automatic av(input logic w, input logic [5:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    {adr, wd, wr, rd} <= {a, dat, w, !w};
    // look at waitrequest mid-cycle, where it is settled before the edge
    @(negedge clk);
    while (wreq !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    // readdata stands through the answering edge; release only after it
    q = rdat;
    @(posedge clk);
    {wr, rd} <= 2'b00;
    chk(32'(n < 50), 32'h1);
  endtask : av
  // host access with fresh values on the shared input pins
  task automatic hx(input logic [2:0] s, input logic a, input logic w, input logic [7:0] dat);
    sh <= 3'($urandom);
    host.xfer(s, a, w, dat, $urandom % 2, h);
  endtask : hx
  function automatic logic [31:0] stat(input logic obf, input logic ibf, input logic cmd);
    return {24'h0, 4'h0, cmd, 1'b0, ibf, obf};
  endfunction : stat
  // main sequence
  initial begin
    {rst, rd, wr, scm, sd_n, adr, wd, sh} = {5'h11, 6'h00, 32'h0, 3'h0};
    err_total = 0;
    comparisons = 0;
    void'($urandom(45253));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    av(0, 6'h00, 0);
    chk(q, 0);
    av(1, 6'h24, 32'hff);
    av(0, 6'h24, 0);
    chk(q, 0);
    av(1, 6'h00, 32'h1);
    scm <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      hx(3'h6, i[0], 1, d);
      av(0, 6'h0c, 0);
      chk(q, stat(0, 1, i[0]));
      av(0, 6'h04, 0);
      chk(q, {24'h0, d});
      av(1, 6'h08, {24'h0, ~d});
      hx(3'h6, 1, 0, 0);
      chk({24'h0, h}, stat(1, 0, i[0]));
      hx(3'h6, 0, 0, 0);
      chk({24'h0, h}, {24'h0, ~d});
    end
    // which pin carries the second select for each setting
    for (int k = 0; k < 3; k++) begin
      av(1, 6'h00, k == 0 ? 32'h1 : (k == 1 ? 32'h5 : 32'hd));
      hx(3'h5, 0, 1, 8'h3c);
      av(0, 6'h18, 0);
      chk(32'(q[1]), 32'(k == 1));
      av(0, 6'h10, 0);
      hx(3'h3, 0, 1, 8'hc3);
      av(0, 6'h18, 0);
      chk(32'(q[1]), 32'(k == 2));
      av(0, 6'h10, 0);
    end
    // random pin functions, shutdown toggled, slave mode dropped at the end
    for (int k = 0; k < 12; k++) begin
      scm <= (k != 11);
      sd_n <= k[0];
      av(1, 6'h00, (32'($urandom) & 32'h7f) | 32'h3);
      hx(3'h6, 0, 1, 8'(k));
      hx(3'h6, 1, 0, 0);
      av(0, 6'h0c, 0);
      chk(32'(q[1]), 32'(scm & sd_n));
      av(0, 6'h04, 0);
    end
    give_verdict();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    chk(0, 1);
    give_verdict();
  end
endmodule : isa_host_port_shutdown_tb
